// >>> ptab_core.sv
`timescale 1ns/1ps
`default_nettype none
module ptab_core
  import ptab_pkg::*;
#(
  parameter int          STACK_DEPTH = 16,
  parameter bit          LARGE_RAM   = 1'b1,
  parameter logic [15:0] PERIPH_IMPL = 16'h000f,
  parameter logic [15:0] RAM_IMPL    = 16'h0003
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // instruction sequencing
  output logic                   first_clock_phase,
  input  wire ptab_pkg::ptab_op_t op,
  input  wire logic [12:0]       opcode,
  input  wire logic              incr_operand,
  input  wire logic              byte_sel,
  input  wire logic [15:0]       int_vector,
  output logic                   busy,
  output logic                   forced_nop,
  output logic [15:0]            pc,
  // data memory access
  input  wire logic [7:0]        dm_addr,
  input  wire logic              dm_rd,
  input  wire logic              dm_wr,
  input  wire logic              dm_rmw,
  input  wire logic [7:0]        dm_wdata,
  output logic [7:0]             dm_rdata,
  output logic                   dm_rvalid,
  // banked registers and ram
  input  wire logic [7:0]        ext_rdata,
  output logic                   ext_rd,
  output logic                   ext_wr,
  output logic [7:0]             bank_selector,
  output logic                   bank_reserved,
  // program memory
  input  wire ptab_pkg::ptab_mode_t mode,
  output logic [15:0]            pm_addr,
  output logic                   pm_rd,
  output logic                   pm_wr,
  output logic [15:0]            pm_wdata,
  output logic                   pm_ext,
  input  wire logic [15:0]       pm_rdata,
  input  wire logic              pm_done
);

  localparam int SPW = $clog2(STACK_DEPTH);
  localparam int PHW = $clog2(Q_PHASES);
  localparam logic [PHW-1:0] PH_LAST = PHW'(Q_PHASES - 1);

  typedef enum logic [1:0] {S_IDLE, S_RD_WAIT, S_WR_WAIT} ptab_fsm_t;

  typedef struct packed {
    logic [PHW-1:0] phase;
    ptab_fsm_t      fsm;
    logic [15:0]    pc;
    logic [7:0]     latch;
    logic [15:0]    tptr;
    logic [15:0]    tblat;
    logic [7:0]     bsel;
    logic [SPW-1:0] sp;
    logic           inc_pend;
    logic [7:0]     dm_rdata;
    logic           dm_rvalid;
    logic           forced_nop;
    logic [15:0]    pm_addr;
    logic           pm_rd;
    logic           pm_wr;
    logic [15:0]    pm_wdata;
    logic           pm_ext;
  } ptab_state_t;

  ptab_state_t st;
  ptab_state_t next_st;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] get_byte(input logic [15:0] w, input logic sel);
    get_byte = sel ? w[15:8] : w[7:0];
  endfunction : get_byte

  function automatic logic [15:0] set_byte(input logic [15:0] w, input logic sel,
                                           input logic [7:0] b);
    set_byte = sel ? {b, w[7:0]} : {w[15:8], b};
  endfunction : set_byte

  // ----------------------------------------
  // bank decode and stack
  // ----------------------------------------
  logic periph_banked;
  logic gpr_banked;
  logic bank_missing;
  logic own_reg;
  logic go;
  logic stk_we;
  logic [SPW-1:0] stk_top;
  logic [15:0] stk_rdata;
  logic [15:0] pc_next;

  ptab_bank_dec #(
    .PERIPH_IMPL (PERIPH_IMPL),
    .RAM_IMPL    (RAM_IMPL),
    .LARGE_RAM   (LARGE_RAM)
  ) u_bank (
    .addr          (dm_addr),
    .bank_selector (st.bsel),
    .periph_banked (periph_banked),
    .gpr_banked    (gpr_banked),
    .bank_missing  (bank_missing),
    .bank_reserved (bank_reserved)
  );

  assign stk_top = SPW'(st.sp - 1'b1);

  // the return address is the next instruction, not the one doing the push
  assign pc_next = st.pc + 16'h0001;

  // read port always follows the top; phases keep pops a full instruction apart
  ptab_stack_mem #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (16)
  ) u_stack (
    .clk   (clk),
    .srst  (srst),
    .we    (stk_we),
    .waddr (st.sp),
    .wdata (pc_next),
    .raddr (stk_top),
    .rdata (stk_rdata)
  );

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  assign first_clock_phase = (st.phase == '0);
  assign busy              = (st.fsm != S_IDLE);
  assign go                = first_clock_phase && !busy;
  assign own_reg = (dm_addr == ADDR_PC_LOW) || (dm_addr == ADDR_PCLATCH)
                || (dm_addr == ADDR_TPTR_LO) || (dm_addr == ADDR_TPTR_HI)
                || (dm_addr == ADDR_BANKSEL);
  assign ext_rd = go && dm_rd && !own_reg && !bank_missing;
  assign ext_wr = go && dm_wr && !own_reg && !bank_missing;
  assign stk_we = go && (op inside {OP_CALL, OP_LONG_CALL, OP_INTVEC});

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st            = st;
    next_st.phase      = (st.phase == PH_LAST) ? '0 : PHW'(st.phase + 1'b1);
    next_st.dm_rvalid  = 1'b0;
    next_st.pm_rd      = 1'b0;
    next_st.pm_wr      = 1'b0;
    next_st.forced_nop = 1'b0;
    if (go) begin
      next_st.pc = st.pc + 16'h0001;
      if (dm_rd) begin
        next_st.dm_rvalid = 1'b1;
        case (dm_addr)
          ADDR_PC_LOW:    next_st.dm_rdata = st.pc[7:0];
          ADDR_PCLATCH:   next_st.dm_rdata = st.latch;
          ADDR_TPTR_LO:   next_st.dm_rdata = st.tptr[7:0];
          ADDR_TPTR_HI:   next_st.dm_rdata = st.tptr[15:8];
          ADDR_BANKSEL:   next_st.dm_rdata = st.bsel;
          default:        next_st.dm_rdata = bank_missing ? BYTE_RESET : ext_rdata;
        endcase
        if (dm_addr == ADDR_PC_LOW && !dm_rmw) begin
          next_st.latch = st.pc[15:8];
        end
      end
      if (dm_wr) begin
        case (dm_addr)
          ADDR_PC_LOW:    next_st.pc = {st.latch, dm_wdata};
          ADDR_PCLATCH:   next_st.latch = dm_wdata;
          ADDR_TPTR_LO:   next_st.tptr[7:0] = dm_wdata;
          ADDR_TPTR_HI:   next_st.tptr[15:8] = dm_wdata;
          ADDR_BANKSEL: begin
            next_st.bsel[3:0] = dm_wdata[3:0];
            if (LARGE_RAM) begin
              next_st.bsel[7:4] = dm_wdata[7:4];
            end
          end
          default: ;
        endcase
      end
      case (op)
        OP_SKIP: next_st.forced_nop = 1'b1;
        OP_GOTO, OP_CALL: begin
          next_st.pc[12:0] = opcode;
          next_st.latch    = {st.pc[15:13], opcode[12:8]};
          if (op == OP_CALL) begin
            next_st.sp = SPW'(st.sp + 1'b1);
          end
        end
        OP_LONG_CALL: begin
          next_st.pc = {st.latch, opcode[7:0]};
          next_st.sp = SPW'(st.sp + 1'b1);
        end
        OP_RETURN: begin
          next_st.latch = st.pc[15:8];
          next_st.pc    = stk_rdata;
          next_st.sp    = stk_top;
        end
        OP_RET_LIT, OP_RET_INT: begin
          next_st.pc = stk_rdata;
          next_st.sp = stk_top;
        end
        OP_INTVEC: begin
          next_st.pc = int_vector;
          next_st.sp = SPW'(st.sp + 1'b1);
        end
        OP_LATCH_WR: next_st.tblat = set_byte(st.tblat, byte_sel, dm_wdata);
        OP_TABLE_WR: begin
          next_st.tblat    = set_byte(st.tblat, byte_sel, dm_wdata);
          next_st.pm_wdata = set_byte(st.tblat, byte_sel, dm_wdata);
          next_st.pm_addr  = st.tptr;
          next_st.pm_wr    = 1'b1;
          next_st.pm_ext   = (mode == MODE_EXT_MCU) || (mode == MODE_MPU);
          next_st.inc_pend = incr_operand;
          next_st.fsm      = S_WR_WAIT;
        end
        OP_LATCH_RD: begin
          next_st.dm_rdata  = get_byte(st.tblat, byte_sel);
          next_st.dm_rvalid = 1'b1;
        end
        OP_TABLE_RD: begin
          // latch byte leaves first, so the word fetched now is for the next read
          next_st.dm_rdata  = get_byte(st.tblat, byte_sel);
          next_st.dm_rvalid = 1'b1;
          next_st.pm_addr   = st.tptr;
          next_st.pm_rd     = 1'b1;
          next_st.pm_ext    = (mode == MODE_EXT_MCU) || (mode == MODE_MPU);
          next_st.inc_pend  = incr_operand;
          next_st.fsm       = S_RD_WAIT;
        end
        OP_PERIPH_BANK: next_st.bsel[3:0] = opcode[3:0];
        OP_RAM_BANK: begin
          if (LARGE_RAM) begin
            next_st.bsel[7:4] = opcode[3:0];
          end
        end
        default: ;
      endcase
    end
    case (st.fsm)
      S_RD_WAIT: begin
        if (pm_done) begin
          next_st.tblat = pm_rdata;
          next_st.fsm   = S_IDLE;
          if (st.inc_pend) begin
            next_st.tptr = st.tptr + 16'h0001;
          end
        end
      end
      S_WR_WAIT: begin
        if (pm_done) begin
          next_st.fsm = S_IDLE;
          if (st.inc_pend) begin
            next_st.tptr = st.tptr + 16'h0001;
          end
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st        <= '0;
      st.fsm    <= S_IDLE;
      st.pc     <= PC_RESET;
      st.latch  <= BYTE_RESET;
      st.bsel   <= BYTE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pc            = st.pc;
  assign forced_nop    = st.forced_nop;
  assign dm_rdata      = st.dm_rdata;
  assign dm_rvalid     = st.dm_rvalid;
  assign bank_selector = st.bsel;
  assign pm_addr       = st.pm_addr;
  assign pm_rd         = st.pm_rd;
  assign pm_wr         = st.pm_wr;
  assign pm_wdata      = st.pm_wdata;
  assign pm_ext        = st.pm_ext;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence plain_fetch_s;
    go && op == OP_FETCH && !(dm_wr && dm_addr == ADDR_PC_LOW);
  endsequence

  sequence tbl_issue_s;
    go && (op == OP_TABLE_RD || op == OP_TABLE_WR) && incr_operand;
  endsequence

  pc_increment_a: assert property (
    plain_fetch_s |=> pc == $past(pc) + 16'h0001)
    else $error("pc did not step by one on a plain fetch");

  call_page_a: assert property (
    go && op == OP_CALL |=> pc[12:0] == $past(opcode)
      && st.latch == {$past(pc[15:13]), $past(opcode[12:8])})
    else $error("call did not load pc and latch page");

  long_call_a: assert property (
    go && op == OP_LONG_CALL |=> pc == {$past(st.latch), $past(opcode[7:0])}
      && st.latch == $past(st.latch))
    else $error("long call target or latch wrong");

  pc_low_write_a: assert property (
    go && op == OP_FETCH && dm_wr && dm_addr == ADDR_PC_LOW
      |=> pc == {$past(st.latch), $past(dm_wdata)})
    else $error("pc low write did not take high byte from latch");

  pc_low_read_a: assert property (
    go && dm_rd && !dm_rmw && dm_addr == ADDR_PC_LOW && op == OP_FETCH
      |=> dm_rvalid && dm_rdata == $past(pc[7:0]) && st.latch == $past(pc[15:8]))
    else $error("pc low read did not copy pc high");

  rmw_latch_a: assert property (
    go && dm_rmw && dm_addr == ADDR_PC_LOW && op == OP_FETCH
      |=> st.latch == $past(st.latch))
    else $error("read-modify-write changed the latch");

  ptr_step_a: assert property (
    busy && pm_done && st.inc_pend
      |=> st.tptr == $past(st.tptr, 1) + 16'h0001)
    else $error("table pointer did not step");

  tbl_busy_a: assert property (
    tbl_issue_s |=> busy && (pm_rd || pm_wr))
    else $error("table transfer did not start");

  tbl_write_a: assert property (
    pm_wr |-> pm_wdata == st.tblat && busy)
    else $error("table write data differs from latch");

  missing_bank_a: assert property (
    go && dm_wr && bank_missing |-> !ext_wr)
    else $error("write reached a missing bank");

  return_pop_a: assert property (
    go && op == OP_RETURN |=> pc == $past(stk_rdata)
      && st.latch == $past(pc[15:8]))
    else $error("return did not restore pc");

endmodule : ptab_core
`default_nettype wire

// >>> ptab_pkg.sv
package ptab_pkg;

  // ----------------------------------------
  // data memory map
  // ----------------------------------------
  localparam logic [7:0] ADDR_PC_LOW    = 8'h02;
  localparam logic [7:0] ADDR_PCLATCH   = 8'h03;
  localparam logic [7:0] ADDR_TPTR_LO   = 8'h0d;
  localparam logic [7:0] ADDR_TPTR_HI   = 8'h0e;
  localparam logic [7:0] ADDR_BANKSEL   = 8'h0f;
  localparam logic [7:0] PERIPH_WIN_LO  = 8'h10;
  localparam logic [7:0] PERIPH_WIN_HI  = 8'h17;
  localparam logic [7:0] GPR_LO         = 8'h20;
  localparam logic [7:0] GPR_HI         = 8'hff;
  localparam logic [3:0] RESERVED_BANK  = 4'hf;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam int          Q_PHASES    = 4;

  // ----------------------------------------
  // instruction classes and modes
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_FETCH, OP_SKIP, OP_GOTO, OP_CALL, OP_LONG_CALL, OP_RETURN,
    OP_RET_LIT, OP_RET_INT, OP_INTVEC, OP_LATCH_WR, OP_TABLE_WR,
    OP_LATCH_RD, OP_TABLE_RD, OP_PERIPH_BANK, OP_RAM_BANK
  } ptab_op_t;

  typedef enum logic [1:0] {
    MODE_MCU, MODE_EXT_MCU, MODE_MPU, MODE_SAFE_MCU
  } ptab_mode_t;

endpackage : ptab_pkg

// >>> ptab_stack_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ptab_stack_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // storage holds no reset; only the read register does
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (srst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : ptab_stack_mem
`default_nettype wire

// >>> ptab_bank_dec.sv
`timescale 1ns/1ps
`default_nettype none
module ptab_bank_dec
  import ptab_pkg::*;
#(
  parameter logic [15:0] PERIPH_IMPL = 16'h000f,
  parameter logic [15:0] RAM_IMPL    = 16'h0003,
  parameter bit          LARGE_RAM   = 1'b1
) (
  // access
  input  wire logic [7:0] addr,
  input  wire logic [7:0] bank_selector,
  // decode
  output logic            periph_banked,
  output logic            gpr_banked,
  output logic            bank_missing,
  output logic            bank_reserved
);

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  always_comb begin
    periph_banked = in_range(addr, PERIPH_WIN_LO, PERIPH_WIN_HI);
    gpr_banked    = LARGE_RAM && in_range(addr, GPR_LO, GPR_HI);
    bank_reserved = periph_banked && (bank_selector[3:0] == RESERVED_BANK);
    bank_missing  = (periph_banked && !PERIPH_IMPL[bank_selector[3:0]])
                 || (gpr_banked && !RAM_IMPL[bank_selector[7:4]]);
  end

endmodule : ptab_bank_dec
`default_nettype wire

// >>> ptab_pm_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptab_pm_model (
  // clock and answer delay
  input  wire logic        clk,
  input  wire logic [1:0]  lag,
  // program memory port
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_rd,
  input  wire logic        pm_wr,
  input  wire logic [15:0] pm_wdata,
  output logic      [15:0] pm_rdata,
  output logic             pm_done
);
  // ----------------------------------------
  // storage, low 256 words only
  // ----------------------------------------
  logic [15:0] mem [256];
  logic [1:0]  cnt;
  logic        act;
  logic        rd_pend;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {~8'(i), 8'(i)};
    end
    pm_rdata = 16'h0000;
    pm_done  = 1'b0;
    act      = 1'b0;
    cnt      = 2'h0;
    rd_pend  = 1'b0;
  end

  // ----------------------------------------
  // answer after 1 to 4 cycles
  // ----------------------------------------
  always @(posedge clk) begin
    pm_done  <= 1'b0;
    // released data bus keeps moving so stale data never looks valid
    pm_rdata <= ~pm_rdata;
    if (pm_rd === 1'b1 || pm_wr === 1'b1) begin
      act     <= 1'b1;
      cnt     <= lag;
      rd_pend <= pm_rd;
      if (pm_wr === 1'b1) begin
        mem[pm_addr[7:0]] <= pm_wdata;
      end
    end else if (act) begin
      if (cnt == 2'h0) begin
        act     <= 1'b0;
        pm_done <= 1'b1;
        if (rd_pend) begin
          pm_rdata <= mem[pm_addr[7:0]];
        end
      end else begin
        cnt <= cnt - 2'h1;
      end
    end
  end
endmodule : ptab_pm_model
`default_nettype wire

// >>> test_ptab_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_ptab_core;
  import ptab_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0, srst = 1'b1, incr_operand = 1'b0, byte_sel = 1'b0;
  logic dm_rd = 1'b0, dm_wr = 1'b0, dm_rmw = 1'b0;
  ptab_op_t op = OP_FETCH;
  ptab_mode_t mode = MODE_MCU;
  logic [12:0] opcode = 13'h0000;
  logic [15:0] int_vector = 16'h0010;
  logic [7:0] dm_addr = 8'h00, dm_wdata = 8'h00, ext_rdata = 8'h00;
  logic [1:0] lag = 2'h0;
  logic first_clock_phase, busy, forced_nop, dm_rvalid, ext_rd, ext_wr, bank_reserved;
  logic pm_rd, pm_wr, pm_ext, pm_done;
  logic [15:0] pc, pm_addr, pm_wdata, pm_rdata;
  logic [7:0] dm_rdata, bank_selector;
  logic seen_rd, seen_wr, seen_rsv;
  int bad_count = 0, checks_done = 0, seed = 71;
  logic [7:0] exp_q[$];

  always #5 clk = ~clk;

  ptab_core u_ptab_core (.clk(clk), .srst(srst), .first_clock_phase(first_clock_phase), .op(op),
    .opcode(opcode), .incr_operand(incr_operand), .byte_sel(byte_sel), .int_vector(int_vector),
    .busy(busy), .forced_nop(forced_nop), .pc(pc), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .dm_rmw(dm_rmw), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_rvalid(dm_rvalid),
    .ext_rdata(ext_rdata), .ext_rd(ext_rd), .ext_wr(ext_wr), .bank_selector(bank_selector),
    .bank_reserved(bank_reserved), .mode(mode), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_wr(pm_wr),
    .pm_wdata(pm_wdata), .pm_ext(pm_ext), .pm_rdata(pm_rdata), .pm_done(pm_done));

  ptab_pm_model u_ptab_pm_model (.clk(clk), .lag(lag), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_wr(pm_wr), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata), .pm_done(pm_done));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  always @(negedge clk) begin
    if (dm_rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(16'(dm_rdata), 16'hxxxx);
      else check(16'(dm_rdata), 16'(exp_q.pop_front()));
    end
  end

  // ----------------------------------------
  // one instruction, presented at the next first clock phase with busy low
  // ----------------------------------------
  // rwm is {read, write, modify}; xe expects the banked register data
  task automatic issue(input ptab_op_t o, input logic [12:0] oc, input logic [7:0] a, input logic [2:0] rwm,
                       input logic [7:0] wd, input logic [7:0] ex, input logic xe = 1'b0,
                       input logic inc = 1'b0, input logic bs = 1'b0);
    int n;
    n = 0;
    while (!(first_clock_phase === 1'b1 && busy === 1'b0) && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      print_verdict();
    end
    op = o;
    opcode = oc;
    dm_addr = a;
    {dm_rd, dm_wr, dm_rmw} = rwm;
    dm_wdata = wd;
    incr_operand = inc;
    byte_sel = bs;
    ext_rdata = 8'($random(seed));
    lag = 2'($random(seed));
    if (rwm[2] || o == OP_LATCH_RD || o == OP_TABLE_RD) exp_q.push_back(xe ? ext_rdata : ex);
    #1;
    seen_rd = ext_rd;
    seen_wr = ext_wr;
    seen_rsv = bank_reserved;
    @(negedge clk);
    op = OP_FETCH;
    {dm_rd, dm_wr, dm_rmw} = 3'b000;
  endtask : issue

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    check(pc, 16'h0000);
    issue(OP_FETCH, 13'h0000, 8'h00, 3'b000, 8'h00, 8'h00);
    check(pc, 16'h0001);
    issue(OP_FETCH, 13'h0000, 8'h03, 3'b010, 8'h12, 8'h00);
    issue(OP_FETCH, 13'h0000, 8'h02, 3'b010, 8'h34, 8'h00);
    check(pc, 16'h1234);
    issue(OP_FETCH, 13'h0000, 8'h03, 3'b010, 8'h77, 8'h00);
    issue(OP_FETCH, 13'h0000, 8'h02, 3'b100, 8'h00, 8'h35);
    issue(OP_FETCH, 13'h0000, 8'h03, 3'b100, 8'h00, 8'h12);
    issue(OP_FETCH, 13'h0000, 8'h03, 3'b010, 8'h40, 8'h00);
    issue(OP_FETCH, 13'h0000, 8'h02, 3'b111, 8'hf0, 8'h38);
    check(pc, 16'h40f0);
    issue(OP_FETCH, 13'h0000, 8'h03, 3'b100, 8'h00, 8'h40);
    issue(OP_GOTO, 13'h0abc, 8'h00, 3'b000, 8'h00, 8'h00);
    check(pc, 16'h4abc);
    issue(OP_FETCH, 13'h0000, 8'h03, 3'b100, 8'h00, 8'h4a);
    issue(OP_CALL, 13'h1555, 8'h00, 3'b000, 8'h00, 8'h00);
    check(pc, 16'h5555);
    issue(OP_LONG_CALL, 13'h1f66, 8'h00, 3'b000, 8'h00, 8'h00);
    check(pc, 16'h5566);
    issue(OP_FETCH, 13'h0000, 8'h03, 3'b010, 8'h9a, 8'h00);
    issue(OP_RETURN, 13'h0000, 8'h00, 3'b000, 8'h00, 8'h00);
    check(pc, 16'h5556);
    issue(OP_FETCH, 13'h0000, 8'h03, 3'b100, 8'h00, 8'h55);
    issue(OP_RET_LIT, 13'h0000, 8'h00, 3'b000, 8'h00, 8'h00);
    check(pc, 16'h4abe);
    issue(OP_INTVEC, 13'h0000, 8'h00, 3'b000, 8'h00, 8'h00);
    check(pc, 16'h0010);
    issue(OP_RET_INT, 13'h0000, 8'h00, 3'b000, 8'h00, 8'h00);
    check(pc, 16'h4abf);
    issue(OP_FETCH, 13'h0000, 8'h03, 3'b100, 8'h00, 8'h55);
    // table write, internal memory, pointer carry into the high byte
    issue(OP_FETCH, 13'h0000, 8'h0d, 3'b010, 8'hff, 8'h00);
    issue(OP_FETCH, 13'h0000, 8'h0e, 3'b010, 8'h00, 8'h00);
    issue(OP_LATCH_WR, 13'h0000, 8'h00, 3'b000, 8'ha5, 8'h00, 1'b0, 1'b0, 1'b1);
    issue(OP_TABLE_WR, 13'h0000, 8'h00, 3'b000, 8'h5a, 8'h00, 1'b0, 1'b1, 1'b0);
    check(pm_addr, 16'h00ff);
    check(pm_wdata, 16'ha55a);
    check(16'(pm_ext), 16'h0000);
    issue(OP_FETCH, 13'h0000, 8'h0d, 3'b100, 8'h00, 8'h00);
    issue(OP_FETCH, 13'h0000, 8'h0e, 3'b100, 8'h00, 8'h01);
    check(u_ptab_pm_model.mem[255], 16'ha55a);
    // table read, external memory, first read returns the old latch
    mode = MODE_MPU;
    issue(OP_FETCH, 13'h0000, 8'h0d, 3'b010, 8'h42, 8'h00);
    issue(OP_FETCH, 13'h0000, 8'h0e, 3'b010, 8'h00, 8'h00);
    issue(OP_TABLE_RD, 13'h0000, 8'h00, 3'b000, 8'h00, 8'ha5, 1'b0, 1'b1, 1'b1);
    check(16'(pm_ext), 16'h0001);
    issue(OP_LATCH_RD, 13'h0000, 8'h00, 3'b000, 8'h00, 8'hbd, 1'b0, 1'b0, 1'b1);
    issue(OP_TABLE_RD, 13'h0000, 8'h00, 3'b000, 8'h00, 8'h42, 1'b0, 1'b0, 1'b0);
    issue(OP_FETCH, 13'h0000, 8'h0d, 3'b100, 8'h00, 8'h43);
    // bank selection
    issue(OP_FETCH, 13'h0000, 8'h0f, 3'b010, 8'h05, 8'h00);
    check(16'(bank_selector), 16'h0005);
    issue(OP_FETCH, 13'h0000, 8'h10, 3'b100, 8'h00, 8'h00);
    check(16'(seen_rd), 16'h0000);
    issue(OP_PERIPH_BANK, 13'h0033, 8'h00, 3'b000, 8'h00, 8'h00);
    check(16'(bank_selector), 16'h0003);
    issue(OP_FETCH, 13'h0000, 8'h10, 3'b100, 8'h00, 8'h00, 1'b1);
    check(16'(seen_rd), 16'h0001);
    issue(OP_RAM_BANK, 13'h0022, 8'h00, 3'b000, 8'h00, 8'h00);
    check(16'(bank_selector), 16'h0023);
    issue(OP_FETCH, 13'h0000, 8'h20, 3'b100, 8'h00, 8'h00);
    issue(OP_FETCH, 13'h0000, 8'h20, 3'b010, 8'h66, 8'h00);
    check(16'(seen_wr), 16'h0000);
    issue(OP_RAM_BANK, 13'h0011, 8'h00, 3'b000, 8'h00, 8'h00);
    issue(OP_FETCH, 13'h0000, 8'h20, 3'b100, 8'h00, 8'h00, 1'b1);
    check(16'(seen_rd), 16'h0001);
    // reserved bank is only written, never read
    issue(OP_PERIPH_BANK, 13'h00ff, 8'h00, 3'b000, 8'h00, 8'h00);
    issue(OP_FETCH, 13'h0000, 8'h10, 3'b010, 8'h00, 8'h00);
    check(16'(seen_rsv), 16'h0001);
    issue(OP_SKIP, 13'h0000, 8'h00, 3'b000, 8'h00, 8'h00);
    check(16'(forced_nop), 16'h0001);
    repeat (2) @(negedge clk);
    check(16'(exp_q.size()), 16'h0000);
    print_verdict();
  end
endmodule : test_ptab_core
`default_nettype wire
